//--- src/ppu_unpacker.sv
// panel pixel word unpacker: link word to dithered 8-bit drive levels
`timescale 1ns/1ns
`include "ppu_defines.svh"
module ppu_unpacker #(
  parameter int H_ACTIVE = `PPU_H_ACTIVE,
  parameter int V_ACTIVE = `PPU_V_ACTIVE,
  parameter int FIFO_DEPTH = `PPU_FIFO_DEPTH
)(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic pixel_valid_window_i,
  input wire logic [`PPU_WORD_W-1:0] link_word_i,
  input wire logic drive_ready_i,
  output logic drive_valid_o,
  output ppu_pkg::ppu_drive_type first_drive_o,
  output ppu_pkg::ppu_drive_type second_drive_o,
  output ppu_pkg::ppu_drive_type third_drive_o,
  output logic [11:0] drive_col_o,
  output logic [11:0] drive_row_o,
  output logic frame_start_o,
  output logic overflow_o
);
  import ppu_pkg::*;
  localparam int PW = 3 * `PPU_COMP_W + 24;

  // =====================
  // word unpacking
  function automatic ppu_pixel_type unpack(input logic [`PPU_WORD_W-1:0] w);
    ppu_pixel_type p;
    p.first = {w[`PPU_FIRST_LO +: 8], w[`PPU_FIRST_B1], w[`PPU_FIRST_B0]};
    p.second = {w[`PPU_SECOND_LO +: 8], w[`PPU_SECOND_LSB +: 2]};
    p.third = {w[`PPU_THIRD_LO +: 8], w[`PPU_THIRD_LSB +: 2]};
    return p;
  endfunction

  // frame-rate dither: round up when 2-bit remainder beats a pattern phase
  function automatic ppu_drive_type dither(input ppu_comp_type c, input logic [1:0] ph);
    logic up;
    up = (c[1:0] > ph) && (c[9:2] != 8'hFF);
    return c[9:2] + 8'(up);
  endfunction

  // =====================
  // input position tracking
  ppu_state_type st_r, st_nxt;
  logic win_r, win_nxt;
  logic [11:0] col_r, col_nxt, row_r, row_nxt;
  logic [11:0] lowcnt_r, lowcnt_nxt;
  logic [11:0] linelen_r, linelen_nxt;
  logic [3:0] lowlines_r, lowlines_nxt;
  logic [1:0] phase_r, phase_nxt;
  logic ovf_r, ovf_nxt;
  logic push;
  logic fs_push;
  logic [PW-1:0] push_data;
  ppu_pixel_type px;

  ppu_stream_if #(.WIDTH(PW)) in_s ();
  ppu_stream_if #(.WIDTH(PW)) out_s ();

  always_comb
  begin
    st_nxt = st_r;
    win_nxt = pixel_valid_window_i;
    col_nxt = col_r;
    row_nxt = row_r;
    lowcnt_nxt = lowcnt_r;
    linelen_nxt = linelen_r;
    lowlines_nxt = lowlines_r;
    phase_nxt = phase_r;
    ovf_nxt = ovf_r;
    push = 1'b0;
    fs_push = 1'b0;
    px = unpack(link_word_i);
    if (pixel_valid_window_i && !win_r)
    begin
      // window rise: start of a line, maybe of a frame
      col_nxt = 12'd0;
      if (lowlines_r >= `PPU_VBLANK_LINES)
      begin
        row_nxt = 12'd0;
        fs_push = 1'b1;
        phase_nxt = phase_r + 2'd1;
      end
      lowcnt_nxt = 12'd0;
      lowlines_nxt = 4'd0;
    end
    else if (!pixel_valid_window_i)
    begin
      // count low time in line periods
      if (lowcnt_r + 12'd1 >= linelen_r && linelen_r != 12'd0)
      begin
        lowcnt_nxt = 12'd0;
        if (lowlines_r != 4'hF)
          lowlines_nxt = lowlines_r + 4'd1;
      end
      else
        lowcnt_nxt = lowcnt_r + 12'd1;
    end
    case (st_r)
      PPU_IDLE:
      begin
        if (pixel_valid_window_i && !win_r)
          st_nxt = PPU_LINE;
      end
      PPU_LINE:
      begin
        if (pixel_valid_window_i && col_r < 12'(H_ACTIVE))
        begin
          push = 1'b1;
          col_nxt = col_r + 12'd1;
        end
        else if (!pixel_valid_window_i)
        begin
          linelen_nxt = col_r + lowcnt_r + 12'd1;
          st_nxt = (col_r < 12'(H_ACTIVE)) ? PPU_FILL : PPU_IDLE;
          if (col_r >= 12'(H_ACTIVE) && row_r < 12'(V_ACTIVE))
            row_nxt = row_r + 12'd1;
        end
      end
      PPU_FILL:
      begin
        // pad the rest of the line with black
        push = 1'b1;
        px = '0;
        col_nxt = col_r + 12'd1;
        if (col_r + 12'd1 >= 12'(H_ACTIVE))
        begin
          st_nxt = PPU_IDLE;
          if (row_r < 12'(V_ACTIVE))
            row_nxt = row_r + 12'd1;
        end
      end
      default:
        st_nxt = PPU_IDLE;
    endcase
    if (row_r >= 12'(V_ACTIVE))
      push = 1'b0;
    if (push && !in_s.ready)
      ovf_nxt = 1'b1;
    push_data = {fs_push || (col_r == 12'd0 && row_r == 12'd0), phase_r, px, col_r, row_r[8:0]};
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_r <= PPU_IDLE;
      win_r <= 1'b0;
      col_r <= 12'd0;
      row_r <= 12'd0;
      lowcnt_r <= 12'd0;
      linelen_r <= 12'd0;
      lowlines_r <= 4'd0;
      phase_r <= 2'd0;
      ovf_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      win_r <= win_nxt;
      col_r <= col_nxt;
      row_r <= row_nxt;
      lowcnt_r <= lowcnt_nxt;
      linelen_r <= linelen_nxt;
      lowlines_r <= lowlines_nxt;
      phase_r <= phase_nxt;
      ovf_r <= ovf_nxt;
    end
  end

  // =====================
  // pixel fifo
  assign in_s.valid = push;
  assign in_s.data = push_data;

  ppu_fifo #(.WIDTH(PW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .in_s(in_s),
    .out_s(out_s)
  );

  // row kept outside fifo word beyond 9 bits: rebuilt on drain side
  logic [11:0] orow_r, orow_nxt;
  logic ov_r, ov_nxt, fs_r, fs_nxt;
  ppu_drive_type d1_r, d1_nxt, d2_r, d2_nxt, d3_r, d3_nxt;
  logic [11:0] ocol_r, ocol_nxt;
  ppu_pixel_type op;
  logic [1:0] oph;
  logic ofs;
  logic [11:0] occ;

  always_comb
  begin
    {ofs, oph, op, occ} = out_s.data[PW-1:9];
    out_s.ready = !ov_r || drive_ready_i;
    ov_nxt = ov_r;
    fs_nxt = fs_r;
    d1_nxt = d1_r;
    d2_nxt = d2_r;
    d3_nxt = d3_r;
    ocol_nxt = ocol_r;
    orow_nxt = orow_r;
    if (out_s.valid && out_s.ready)
    begin
      ov_nxt = 1'b1;
      fs_nxt = ofs;
      d1_nxt = dither(op.first, oph);
      d2_nxt = dither(op.second, oph ^ 2'd1);
      d3_nxt = dither(op.third, oph ^ 2'd2);
      ocol_nxt = occ;
      if (ofs)
        orow_nxt = 12'd0;
      else if (occ == 12'd0)
        orow_nxt = orow_r + 12'd1;
    end
    else if (drive_ready_i)
    begin
      ov_nxt = 1'b0;
      fs_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ov_r <= 1'b0;
      fs_r <= 1'b0;
      d1_r <= '0;
      d2_r <= '0;
      d3_r <= '0;
      ocol_r <= 12'd0;
      orow_r <= 12'd0;
    end
    else
    begin
      ov_r <= ov_nxt;
      fs_r <= fs_nxt;
      d1_r <= d1_nxt;
      d2_r <= d2_nxt;
      d3_r <= d3_nxt;
      ocol_r <= ocol_nxt;
      orow_r <= orow_nxt;
    end
  end

  assign drive_valid_o = ov_r;
  assign frame_start_o = fs_r;
  assign first_drive_o = d1_r;
  assign second_drive_o = d2_r;
  assign third_drive_o = d3_r;
  assign drive_col_o = ocol_r;
  assign drive_row_o = orow_r;
  assign overflow_o = ovf_r;
endmodule // ppu_unpacker

//--- src/ppu_defines.svh
// constants for the panel pixel word unpacker
`ifndef PPU_DEFINES_SVH
`define PPU_DEFINES_SVH
`define PPU_H_ACTIVE 12'd3840
`define PPU_V_ACTIVE 12'd2160
`define PPU_VBLANK_LINES 4'd8
`define PPU_COMP_W 10
`define PPU_DRIVE_W 8
`define PPU_WORD_W 32
`define PPU_FIFO_DEPTH 8
`define PPU_FIRST_LO 0
`define PPU_SECOND_LO 8
`define PPU_THIRD_LO 16
`define PPU_THIRD_LSB 26
`define PPU_SECOND_LSB 28
`define PPU_FIRST_B0 30
`define PPU_FIRST_B1 31
`endif

//--- src/ppu_pkg.sv
// types for the panel pixel word unpacker
package ppu_pkg;
  typedef logic [9:0] ppu_comp_type;
  typedef logic [7:0] ppu_drive_type;
  typedef struct packed
  {
    ppu_comp_type first;
    ppu_comp_type second;
    ppu_comp_type third;
  } ppu_pixel_type;
  typedef enum logic [1:0] {PPU_IDLE, PPU_LINE, PPU_FILL} ppu_state_type;
endpackage

//--- src/ppu_stream_if.sv
// valid/ready pixel stream between unpacker and its fifo
`timescale 1ns/1ns
interface ppu_stream_if #(parameter int WIDTH = 32);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

//--- src/ppu_fifo.sv
// small pixel fifo with registered read data
`timescale 1ns/1ns
module ppu_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
)(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  ppu_stream_if.snk in_s,
  ppu_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic [WIDTH-1:0] dout_r, dout_nxt;
  logic ov_r, ov_nxt;
  logic wr, rd;
  // =====================
  // next state
  always_comb
  begin
    wr = in_s.valid && (cnt_r != AW'(0) + (AW+1)'(DEPTH));
    rd = (cnt_r != '0) && (!ov_r || out_s.ready);
    wp_nxt = wr ? wp_r + AW'(1) : wp_r;
    rp_nxt = rd ? rp_r + AW'(1) : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
    dout_nxt = rd ? mem_r[rp_r] : dout_r;
    ov_nxt = rd ? 1'b1 : (out_s.ready ? 1'b0 : ov_r);
  end
  // =====================
  // registers
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      dout_r <= '0;
      ov_r <= 1'b0;
    end
    else
    begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      dout_r <= dout_nxt;
      ov_r <= ov_nxt;
    end
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (wr)
      mem_r[wp_r] <= in_s.data;
  end
  assign in_s.ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_s.valid = ov_r;
  assign out_s.data = dout_r;
endmodule // ppu_fifo

//--- tb/ppu_src_model.sv
// video source model: frames pixels with the window signal
`timescale 1ns/1ns
module ppu_src_model (
  input wire logic sys_clk_i,
  output logic window_o,
  output logic [31:0] word_o
);
  import ppu_pkg::*;
  initial window_o = 1'b0;
  initial word_o = '0;
  // one word per clock; idle word keeps toggling
  task automatic drive(input logic win, input ppu_pixel_type p);
    @(negedge sys_clk_i);
    window_o = win;
    word_o = win ? {p.first[1:0], p.second[1:0], p.third[1:0], 2'($urandom), p.third[9:2], p.second[9:2],
      p.first[9:2]} : ~word_o;
  endtask
endmodule // ppu_src_model

//--- tb/ppu_unpacker_sva.sv
// checker for the pixel word unpacker ports
`timescale 1ns/1ns
module ppu_unpacker_sva #(
  parameter int H_ACTIVE = 3840,
  parameter int V_ACTIVE = 2160
)(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic pixel_valid_window_i,
  input wire logic [31:0] link_word_i,
  input wire logic drive_ready_i,
  input wire logic drive_valid_o,
  input wire ppu_pkg::ppu_drive_type first_drive_o,
  input wire ppu_pkg::ppu_drive_type second_drive_o,
  input wire ppu_pkg::ppu_drive_type third_drive_o,
  input wire logic [11:0] drive_col_o,
  input wire logic [11:0] drive_row_o,
  input wire logic frame_start_o,
  input wire logic overflow_o
);
  import ppu_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // ==========
  // last accepted position
  logic hs;
  logic seen_r;
  logic [11:0] pcol_r;
  logic [11:0] prow_r;
  assign hs = drive_valid_o && drive_ready_i;
  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      seen_r <= 1'b0;
      pcol_r <= '0;
      prow_r <= '0;
    end
    else if (hs)
    begin
      seen_r <= 1'b1;
      pcol_r <= drive_col_o;
      prow_r <= drive_row_o;
    end
  // ==========
  // assertions
  stand_valid_a: assert property (drive_valid_o && !drive_ready_i |=> drive_valid_o)
    else $error("drive valid dropped while stalled");
  stand_data_a: assert property (drive_valid_o && !drive_ready_i |=>
    $stable({first_drive_o, second_drive_o, third_drive_o, drive_col_o, drive_row_o}))
    else $error("drive data moved while stalled");
  pos_range_a: assert property (drive_valid_o |-> drive_col_o < H_ACTIVE && drive_row_o < V_ACTIVE)
    else $error("drive position out of range");
  frame_origin_a: assert property (frame_start_o |-> drive_valid_o && drive_col_o == 0 && drive_row_o == 0)
    else $error("frame start off origin");
  col_step_a: assert property (hs && seen_r |->
    drive_col_o == ((pcol_r == H_ACTIVE - 1) ? 12'h000 : pcol_r + 12'h001))
    else $error("column sequence broken");
  row_step_a: assert property (hs && seen_r |->
    drive_row_o == ((pcol_r != H_ACTIVE - 1) ? prow_r : (prow_r == V_ACTIVE - 1) ? 12'h000 : prow_r + 12'h001))
    else $error("row sequence broken");
  overflow_hold_a: assert property (overflow_o |=> overflow_o) else $error("overflow flag cleared");
  start_latency_a: assert property ($rose(pixel_valid_window_i) && !drive_valid_o ##1
    drive_ready_i && !drive_valid_o |-> ##[1:4] drive_valid_o) else $error("first pixel late");
  cover property (frame_start_o);
  cover property ($rose(overflow_o));
  cover property (drive_valid_o && !drive_ready_i ##1 drive_ready_i);
endmodule // ppu_unpacker_sva
bind ppu_unpacker ppu_unpacker_sva #(.H_ACTIVE(H_ACTIVE), .V_ACTIVE(V_ACTIVE)) ppu_unpacker_sva_inst (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .pixel_valid_window_i(pixel_valid_window_i), .link_word_i(link_word_i),
  .drive_ready_i(drive_ready_i), .drive_valid_o(drive_valid_o), .first_drive_o(first_drive_o),
  .second_drive_o(second_drive_o), .third_drive_o(third_drive_o), .drive_col_o(drive_col_o),
  .drive_row_o(drive_row_o), .frame_start_o(frame_start_o), .overflow_o(overflow_o));

//--- tb/testbench.sv
// self-checking bench for the pixel word unpacker
`timescale 1ns/1ns
module testbench;
  import ppu_pkg::*;
  localparam int H = 8;
  localparam int V = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rdy = 1'b0;
  logic rdy_rand = 1'b0;
  logic win;
  logic [31:0] word;
  logic drv_v, fs, ovf;
  ppu_drive_type d1, d2, d3;
  logic [11:0] col, row, ec, er;
  int n_fail = 0;
  int check_count = 0;
  int nf = 0;
  ppu_pixel_type q[$];
  ppu_pixel_type ep;
  initial forever #20 clk = ~clk;
  always @(negedge clk) rdy <= rdy_rand && ($urandom % 4 != 0);
  ppu_src_model ppu_src_model_inst (.sys_clk_i(clk), .window_o(win), .word_o(word));
  ppu_unpacker #(.H_ACTIVE(H), .V_ACTIVE(V)) ppu_unpacker_inst (.sys_clk_i(clk), .rst_i(rst),
    .pixel_valid_window_i(win), .link_word_i(word), .drive_ready_i(rdy), .drive_valid_o(drv_v),
    .first_drive_o(d1), .second_drive_o(d2), .third_drive_o(d3), .drive_col_o(col), .drive_row_o(row),
    .frame_start_o(fs), .overflow_o(ovf));
  // ==========
  // compare tasks
  task automatic cmp_val(input string n, input logic [11:0] e, input logic [11:0] g);
    check_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp_drv(input string n, input ppu_drive_type e, input ppu_drive_type g);
    check_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // expected drive level: upper bits, bumped when remainder beats the frame phase
  function automatic ppu_drive_type exp_drive(input ppu_comp_type c, input logic [1:0] ph);
    exp_drive = c[9:2];
    if (c[1:0] > ph && c[9:2] != 8'hff)
      exp_drive = c[9:2] + 8'h01;
  endfunction
  task automatic print_verdict;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ==========
  // one line: lead cycle, pixels, gap; kind 0 black, 1 white, 2 primaries, 3 random
  task automatic line(input int n, input int kind);
    ppu_pixel_type p;
    ppu_src_model_inst.drive(1'b1, 30'($urandom));
    for (int i = 0; i < n; i++)
    begin
      case (kind)
        0: p = '0;
        1: p = '1;
        2: p = 30'h3ff << (10 * (i % 3));
        default: p = 30'($urandom);
      endcase
      q.push_back(p);
      ppu_src_model_inst.drive(1'b1, p);
    end
    for (int i = n; i < H; i++)
      q.push_back('0);
    repeat (10) ppu_src_model_inst.drive(1'b0, '0);
  endtask
  always @(posedge clk)
  begin
    if (!rst && drv_v === 1'b1 && rdy)
    begin
      ep = q.pop_front();
      cmp_drv("first", exp_drive(ep.first, 2'(nf)), d1);
      cmp_drv("second", exp_drive(ep.second, 2'(nf) ^ 2'd1), d2);
      cmp_drv("third", exp_drive(ep.third, 2'(nf) ^ 2'd2), d3);
      cmp_val("col", ec, col);
      cmp_val("row", er, row);
      if (nf > 0 || ec != 0 || er != 0)
        cmp_val("start", {11'h000, ec == 0 && er == 0}, {11'h000, fs});
      ec = (ec == H - 1) ? 12'h000 : ec + 12'h001;
      if (ec == 0)
      begin
        nf += (er == V - 1);
        er = (er == V - 1) ? 12'h000 : er + 12'h001;
      end
    end
  end
  initial
  begin
    ec = '0;
    er = '0;
    void'($urandom(32'ha1c2_5f25));
    repeat (6) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    cmp_val("valid", 12'h000, {11'h000, drv_v});
    rdy_rand = 1'b1;
    for (int f = 0; f < 4; f++)
    begin
      for (int r = 0; r < V; r++)
        line(f == 0 ? (r == V - 1 ? 5 : H) : 1 + $urandom % H, f == 0 ? r : 3);
      repeat (170) ppu_src_model_inst.drive(1'b0, '0);
      $display("test %0d done", f);
    end
    for (int i = 0; i < 500 && q.size() != 0; i++) @(posedge clk);
    cmp_val("left", 12'h000, 12'(q.size()));
    cmp_val("ovf", 12'h000, {11'h000, ovf});
    rdy_rand = 1'b0;
    line(H, 3);
    line(H, 3);
    cmp_val("ovf", 12'h001, {11'h000, ovf});
    @(negedge clk) rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    cmp_val("ovf", 12'h000, {11'h000, ovf});
    cmp_val("valid", 12'h000, {11'h000, drv_v});
    $display("test overflow done");
    print_verdict;
  end
  initial
  begin
    #800000;
    n_fail++;
    print_verdict;
  end
endmodule // testbench
